// ### arcbe_pkg.sv
package arcbe_pkg;

  // opcode fields
  localparam logic [5:0]  AND_OPC        = 6'h05;
  localparam logic [7:0]  CBR_OPC        = 8'hE2;
  localparam int          DEST_BIT       = 9;
  localparam int          BANK_BIT       = 8;

  // data memory addressing
  localparam logic [7:0]  ILO_MAX        = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
  localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;

  // status flag positions
  localparam int          C_BIT          = 0;
  localparam int          DC_BIT         = 1;
  localparam int          Z_BIT          = 2;
  localparam int          OV_BIT         = 3;
  localparam int          N_BIT          = 4;

  localparam logic [20:0] PC_STEP        = 21'h000002;

  // register byte offsets
  localparam logic [11:0] CTRL_OFS       = 12'h000;
  localparam logic [11:0] ACCUM_OFS      = 12'h004;
  localparam logic [11:0] BANK_OFS       = 12'h008;
  localparam logic [11:0] STATUS_OFS     = 12'h00C;
  localparam logic [11:0] INDEX_OFS      = 12'h010;
  localparam logic [11:0] PC_OFS         = 12'h014;
  localparam logic [11:0] EXEC_OFS       = 12'h018;

  // values after reset
  localparam logic        CTRL_RST       = 1'b0;
  localparam logic [7:0]  ACCUM_RST      = 8'h00;
  localparam logic [3:0]  BANK_RST       = 4'h0;
  localparam logic [4:0]  STATUS_RST     = 5'h00;
  localparam logic [11:0] INDEX_RST      = 12'h000;
  localparam logic [20:0] PC_RST         = 21'h000000;

  typedef enum logic [3:0] {
    PH_DECODE = 4'b0001,
    PH_READ   = 4'b0010,
    PH_PROC   = 4'b0100,
    PH_WRITE  = 4'b1000
  } arcbe_phase_t;

endpackage

// ### arcbe_dec_if.sv
`timescale 1ns/10ps
interface arcbe_dec_if;
  logic [15:0] instr;
  logic [7:0]  accum;
  logic [7:0]  fdata;
  logic [3:0]  bank;
  logic [11:0] index_base;
  logic        ext_en;
  logic        carry;
  logic [20:0] pc;
  logic        is_and;
  logic        is_cbr;
  logic        dest_file;
  logic        taken;
  logic [11:0] faddr;
  logic [7:0]  result;
  logic        res_zero;
  logic        res_neg;
  logic [20:0] target;

  modport core (
    output instr, accum, fdata, bank, index_base, ext_en, carry, pc,
    input  is_and, is_cbr, dest_file, taken, faddr, result, res_zero,
    input  res_neg, target
  );
  modport dec (
    input  instr, accum, fdata, bank, index_base, ext_en, carry, pc,
    output is_and, is_cbr, dest_file, taken, faddr, result, res_zero,
    output res_neg, target
  );
endinterface

// ### arcbe_decode.sv
`timescale 1ns/10ps
module arcbe_decode (
  // decode operands and results
  arcbe_dec_if.dec d
);
  logic [7:0] f;

  always_comb begin
    f = d.instr[7:0];
    d.is_and    = (d.instr[15:10] == arcbe_pkg::AND_OPC);
    d.is_cbr    = (d.instr[15:8] == arcbe_pkg::CBR_OPC);
    d.dest_file = d.instr[arcbe_pkg::DEST_BIT];
    if (d.instr[arcbe_pkg::BANK_BIT]) begin
      d.faddr = {d.bank, f};
    end else if (d.ext_en && (f <= arcbe_pkg::ILO_MAX)) begin
      d.faddr = d.index_base + {4'h0, f};
    end else if (f < arcbe_pkg::ACCESS_SPLIT) begin
      d.faddr = {arcbe_pkg::ACCESS_LO_BANK, f};
    end else begin
      d.faddr = {arcbe_pkg::ACCESS_HI_BANK, f};
    end
    d.result   = d.accum & d.fdata;
    d.res_zero = (d.result == 8'h00);
    d.res_neg  = d.result[7];
    d.taken    = d.is_cbr && d.carry;
    // signed offset doubled, added to the already-advanced address
    d.target = d.pc + arcbe_pkg::PC_STEP
               + {{12{f[7]}}, f, 1'b0};
  end
endmodule

// ### arcbe_core.sv
`timescale 1ns/10ps
// Functional notes
// - AND accumulator with file register, N and Z
// - destination bit 0 accumulator, 1 file register
// - bank bit 0 access bank, 1 bank select
// - extended set, access bank, f<=95 indexed
// - carry branch only when carry set, no flags
// - taken target is advanced address plus 2n
// - branch one cycle, taken adds nop cycle
module arcbe_core (
  // clock, reset, enable
  input  wire  logic        clk,
  input  wire  logic        reset,
  input  wire  logic        clk_en,
  // apb slave
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [11:0] paddr,
  input  wire  logic [31:0] pwdata,
  output logic       [31:0] prdata,
  output logic              pready,
  output logic              pslverr,
  // instruction fetch
  input  wire  logic        instr_valid,
  input  wire  logic [15:0] instr_word,
  output logic              instr_ready,
  output logic       [20:0] program_counter,
  output logic              flush_active,
  // file register port
  output logic       [11:0] file_addr,
  input  wire  logic [7:0]  file_rdata,
  output logic              file_we,
  output logic       [7:0]  file_wdata
);
  arcbe_pkg::arcbe_phase_t phase_r, phase_nxt;
  logic [15:0] instr_r, instr_nxt;
  logic        active_r, active_nxt;
  logic        flush_r, flush_nxt;
  logic [7:0]  fdata_r, fdata_nxt;
  logic [11:0] faddr_r, faddr_nxt;
  logic        we_r, we_nxt;
  logic [7:0]  wdata_r, wdata_nxt;
  logic [7:0]  accum_r, accum_nxt;
  logic [4:0]  status_r, status_nxt;
  logic [20:0] pc_r, pc_nxt;
  logic [3:0]  bank_r, bank_nxt;
  logic [11:0] index_r, index_nxt;
  logic        ext_r, ext_nxt;
  logic        addr_ok;
  logic        apb_wr;
  logic        commit;
  logic [20:0] cbr_ofs_w;
  logic [31:0] prdata_r, prdata_nxt;
  logic        rd_armed_r, rd_armed_nxt;

  arcbe_dec_if dif ();

  arcbe_decode u_decode (
    .d (dif.dec)
  );

  assign dif.instr      = instr_r;
  assign dif.accum      = accum_r;
  assign dif.fdata      = fdata_r;
  assign dif.bank       = bank_r;
  assign dif.index_base = index_r;
  assign dif.ext_en     = ext_r;
  assign dif.carry      = status_r[arcbe_pkg::C_BIT];
  assign dif.pc         = pc_r;

  assign addr_ok = (paddr == arcbe_pkg::CTRL_OFS)
                || (paddr == arcbe_pkg::ACCUM_OFS)
                || (paddr == arcbe_pkg::BANK_OFS)
                || (paddr == arcbe_pkg::STATUS_OFS)
                || (paddr == arcbe_pkg::INDEX_OFS)
                || (paddr == arcbe_pkg::PC_OFS)
                || (paddr == arcbe_pkg::EXEC_OFS);
  assign pready  = psel && penable && clk_en && rd_armed_r;
  assign pslverr = pready && !addr_ok;
  assign apb_wr  = pready && pwrite && addr_ok;
  assign commit  = clk_en && (phase_r == arcbe_pkg::PH_WRITE) && active_r;
  assign cbr_ofs_w = {{12{instr_r[7]}}, instr_r[7:0], 1'b0};

  assign instr_ready = clk_en && (phase_r == arcbe_pkg::PH_DECODE)
                       && !flush_r;
  assign program_counter = pc_r;
  assign prdata          = prdata_r;
  assign flush_active    = flush_r;
  assign file_addr       = faddr_r;
  assign file_we         = we_r;
  assign file_wdata      = wdata_r;

  // read data is a snapshot taken once per transfer, so it leaves a flop
  always_comb begin
    prdata_nxt   = prdata_r;
    rd_armed_nxt = rd_armed_r;
    if (pready) begin
      rd_armed_nxt = 1'b0;
    end else if (psel && !rd_armed_r) begin
      rd_armed_nxt = 1'b1;
      case (paddr)
        arcbe_pkg::CTRL_OFS:   prdata_nxt = {31'h00000000, ext_r};
        arcbe_pkg::ACCUM_OFS:  prdata_nxt = {24'h000000, accum_r};
        arcbe_pkg::BANK_OFS:   prdata_nxt = {28'h0000000, bank_r};
        arcbe_pkg::STATUS_OFS: prdata_nxt = {27'h0000000, status_r};
        arcbe_pkg::INDEX_OFS:  prdata_nxt = {20'h00000, index_r};
        arcbe_pkg::PC_OFS:     prdata_nxt = {11'h000, pc_r};
        arcbe_pkg::EXEC_OFS:   prdata_nxt = {instr_r, 10'h000, active_r,
                                             flush_r, phase_r};
        default:               prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_comb begin
    phase_nxt  = phase_r;
    instr_nxt  = instr_r;
    active_nxt = active_r;
    flush_nxt  = flush_r;
    fdata_nxt  = fdata_r;
    faddr_nxt  = faddr_r;
    we_nxt     = 1'b0;
    wdata_nxt  = wdata_r;
    accum_nxt  = accum_r;
    status_nxt = status_r;
    pc_nxt     = pc_r;
    bank_nxt   = bank_r;
    index_nxt  = index_r;
    ext_nxt    = ext_r;
    // software writes first, so the instruction update below wins
    if (apb_wr) begin
      case (paddr)
        arcbe_pkg::CTRL_OFS:   ext_nxt    = pwdata[0];
        arcbe_pkg::ACCUM_OFS:  accum_nxt  = pwdata[7:0];
        arcbe_pkg::BANK_OFS:   bank_nxt   = pwdata[3:0];
        arcbe_pkg::STATUS_OFS: status_nxt = pwdata[4:0];
        arcbe_pkg::INDEX_OFS:  index_nxt  = pwdata[11:0];
        arcbe_pkg::PC_OFS:     pc_nxt     = {pwdata[20:1], 1'b0};
        default:               ext_nxt    = ext_r;
      endcase
    end
    case (phase_r)
      arcbe_pkg::PH_DECODE: begin
        if (flush_r) begin
          active_nxt = 1'b0;
          phase_nxt  = arcbe_pkg::PH_READ;
        end else if (instr_valid) begin
          instr_nxt  = instr_word;
          active_nxt = 1'b1;
          phase_nxt  = arcbe_pkg::PH_READ;
        end
      end
      arcbe_pkg::PH_READ: begin
        if (active_r && dif.is_and) begin
          faddr_nxt = dif.faddr;
        end
        phase_nxt = arcbe_pkg::PH_PROC;
      end
      arcbe_pkg::PH_PROC: begin
        if (active_r && dif.is_and) begin
          fdata_nxt = file_rdata;
        end
        phase_nxt = arcbe_pkg::PH_WRITE;
      end
      arcbe_pkg::PH_WRITE: begin
        phase_nxt = arcbe_pkg::PH_DECODE;
        flush_nxt = 1'b0;
        if (active_r) begin
          pc_nxt = pc_r + arcbe_pkg::PC_STEP;
          if (dif.is_and) begin
            status_nxt[arcbe_pkg::N_BIT] = dif.res_neg;
            status_nxt[arcbe_pkg::Z_BIT] = dif.res_zero;
            if (dif.dest_file) begin
              we_nxt    = 1'b1;
              wdata_nxt = dif.result;
            end else begin
              accum_nxt = dif.result;
            end
          end else if (dif.taken) begin
            pc_nxt    = dif.target;
            flush_nxt = 1'b1;
          end
        end
      end
      default: phase_nxt = arcbe_pkg::PH_DECODE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      phase_r  <= arcbe_pkg::PH_DECODE;
      instr_r  <= 16'h0000;
      active_r <= 1'b0;
      flush_r  <= 1'b0;
      fdata_r  <= 8'h00;
      faddr_r  <= 12'h000;
      we_r     <= 1'b0;
      wdata_r  <= 8'h00;
      accum_r  <= arcbe_pkg::ACCUM_RST;
      status_r <= arcbe_pkg::STATUS_RST;
      pc_r     <= arcbe_pkg::PC_RST;
      bank_r   <= arcbe_pkg::BANK_RST;
      index_r  <= arcbe_pkg::INDEX_RST;
      ext_r    <= arcbe_pkg::CTRL_RST;
      prdata_r <= 32'h00000000;
      rd_armed_r <= 1'b0;
    end else if (clk_en) begin
      phase_r  <= phase_nxt;
      instr_r  <= instr_nxt;
      active_r <= active_nxt;
      flush_r  <= flush_nxt;
      fdata_r  <= fdata_nxt;
      faddr_r  <= faddr_nxt;
      we_r     <= we_nxt;
      wdata_r  <= wdata_nxt;
      accum_r  <= accum_nxt;
      status_r <= status_nxt;
      pc_r     <= pc_nxt;
      bank_r   <= bank_nxt;
      index_r  <= index_nxt;
      ext_r    <= ext_nxt;
      prdata_r <= prdata_nxt;
      rd_armed_r <= rd_armed_nxt;
    end
  end

  a_and_flags_set: assert property (@(posedge clk)
    disable iff (reset) commit && dif.is_and && !apb_wr |=>
      status_r[arcbe_pkg::N_BIT] == $past(fdata_r[7] & accum_r[7])
      && status_r[arcbe_pkg::Z_BIT] == ($past(dif.result) == 0)
      && status_r[arcbe_pkg::C_BIT] == $past(status_r[arcbe_pkg::C_BIT]))
    else $error("and flags wrong");

  a_and_to_accum: assert property (@(posedge clk)
    disable iff (reset)
    commit && dif.is_and && !dif.dest_file |=>
      accum_r == ($past(fdata_r) & $past(accum_r)) && !file_we)
    else $error("and result not in accumulator");

  a_and_to_file: assert property (@(posedge clk) disable iff (reset)
    commit && dif.is_and && dif.dest_file && !apb_wr |=> file_we
      && file_wdata == ($past(fdata_r) & $past(accum_r))
      && accum_r == $past(accum_r) ##1 !file_we || !$past(clk_en))
    else $error("and result not written to file");

  a_bank_select: assert property (@(posedge clk) disable iff (reset)
    clk_en && phase_r == arcbe_pkg::PH_READ && active_r && dif.is_and
      && instr_r[arcbe_pkg::BANK_BIT] |=>
      file_addr == {$past(bank_r), $past(instr_r[7:0])})
    else $error("bank select address wrong");

  a_index_offset: assert property (@(posedge clk)
    disable iff (reset)
    clk_en && phase_r == arcbe_pkg::PH_READ && active_r && dif.is_and
      && !instr_r[arcbe_pkg::BANK_BIT] && ext_r
      && instr_r[7:0] <= arcbe_pkg::ILO_MAX |=>
      file_addr == 12'($past(index_r) + {4'h0, $past(instr_r[7:0])}))
    else $error("indexed offset address wrong");

  a_cbr_no_flags: assert property (@(posedge clk)
    disable iff (reset)
    commit && dif.is_cbr && !apb_wr |=> status_r == $past(status_r)
      && accum_r == $past(accum_r))
    else $error("carry branch changed state");

  a_cbr_target: assert property (@(posedge clk) disable iff (reset)
    commit && dif.is_cbr && status_r[arcbe_pkg::C_BIT] |=>
      pc_r == 21'($past(pc_r) + arcbe_pkg::PC_STEP + $past(cbr_ofs_w)))
    else $error("branch target wrong");

  a_cbr_not_taken: assert property (@(posedge clk)
    disable iff (reset)
    commit && dif.is_cbr && !status_r[arcbe_pkg::C_BIT] |=>
      !flush_r && pc_r == 21'($past(pc_r) + arcbe_pkg::PC_STEP))
    else $error("untaken branch not single cycle");

  a_cbr_nop_cycle: assert property (@(posedge clk)
    disable iff (reset)
    commit && dif.taken |=> flush_r && !instr_ready
      && phase_r == arcbe_pkg::PH_DECODE)
    else $error("taken branch without nop cycle");

  a_nop_no_effect: assert property (@(posedge clk)
    disable iff (reset)
    clk_en && flush_r && phase_r == arcbe_pkg::PH_WRITE && !apb_wr |=>
      !flush_r && pc_r == $past(pc_r) && !file_we)
    else $error("nop cycle had an effect");

  a_accept_phase: assert property (@(posedge clk)
    disable iff (reset)
    instr_valid && instr_ready |=> phase_r == arcbe_pkg::PH_READ
      && active_r && instr_r == $past(instr_word))
    else $error("instruction not taken into decode");

endmodule

// ### arcbe_core_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks++; if ((ex) !== (got)) begin \
  failures++; $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); \
  end end
module arcbe_core_tb_top;
  logic        clk, reset, clk_en, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic        instr_valid, instr_ready, flush_active;
  logic [15:0] instr_word;
  logic [20:0] program_counter, pc0, epc;
  logic [11:0] file_addr, we_addr, ea, ix;
  logic [7:0]  file_rdata, fkey, we_data, w8, f, n, res, we_data_w;
  logic        file_we, d, a, ext, er, stall;
  logic [3:0]  bk;
  logic [4:0]  st, est;
  logic [31:0] rd;
  int          failures, checks, cyc, we_cnt, lows, fl, i;
  int          seed = 32'hb41e;
  logic [7:0]  fc [4] = '{8'h5F, 8'h60, 8'h00, 8'hFF};

  arcbe_core i_arcbe_core (
    .clk(clk), .reset(reset), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .program_counter(program_counter),
    .flush_active(flush_active), .file_addr(file_addr),
    .file_rdata(file_rdata), .file_we(file_we), .file_wdata(we_data_w)
  );

  // data memory model: high nibble varies with address and per run, low nibble only per run
  function automatic logic [7:0] fmem(logic [11:0] ad, logic [7:0] k);
    return ad[7:0] ^ {ad[11:8], ad[3:0]} ^ k;
  endfunction
  assign file_rdata = fmem(file_addr, fkey);

  function automatic logic [11:0] exp_addr(logic aa, logic ee,
      logic [7:0] ff, logic [3:0] bb, logic [11:0] xx);
    if (aa)
      return {bb, ff};
    if (ee && ff <= arcbe_pkg::ILO_MAX)
      return xx + {4'h0, ff};
    if (ff < arcbe_pkg::ACCESS_SPLIT)
      return {arcbe_pkg::ACCESS_LO_BANK, ff};
    return {arcbe_pkg::ACCESS_HI_BANK, ff};
  endfunction

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (file_we === 1'b1 && clk_en === 1'b1) begin
      we_cnt++;
      we_addr = file_addr;
      we_data = we_data_w;
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      finish_test();
    end
  end

  // random enable stalls once stall is on
  always @(posedge clk) begin
    if (stall)
      clk_en <= (($random(seed) & 3) != 0);
  end

  task automatic apb(input logic wr, input logic [11:0] ad,
      input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run_instr(input logic [15:0] wd);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word  <= wd;
    @(posedge clk);
    while (instr_ready !== 1'b1)
      @(posedge clk);
    instr_valid <= 1'b0;
    lows = 0;
    fl   = 0;
    #1;
    for (int k = 0; k < 80 && instr_ready !== 1'b1; k++) begin
      if (clk_en === 1'b1) begin
        lows++;
        if (flush_active === 1'b1)
          fl++;
      end
      @(posedge clk);
      #1;
    end
    if (instr_ready !== 1'b1)
      failures++;
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    clk = 0; reset = 1; clk_en = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; instr_valid = 0; instr_word = 0; fkey = 0;
    failures = 0; checks = 0; cyc = 0; we_cnt = 0; stall = 0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    for (i = 0; i < 6; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      `CHK("reset value", 32'h0, rd)
    end
    apb(1'b0, arcbe_pkg::EXEC_OFS, 32'h0);
    `CHK("exec phase", 5'h01, rd[4:0])
    apb(1'b0, 12'h01C, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    stall <= 1'b1;
    for (i = 0; i < 40; i++) begin
      w8 = $random(seed); f = (i < 4) ? fc[i] : 8'($random(seed));
      bk = $random(seed); ix = $random(seed); st = $random(seed);
      pc0 = $random(seed); pc0[0] = 1'b0; {d, a, ext} = $random(seed);
      if (i < 4) {a, ext} = 2'b01;
      fkey <= $random(seed);
      apb(1'b1, arcbe_pkg::CTRL_OFS, {31'h0, ext});
      apb(1'b1, arcbe_pkg::ACCUM_OFS, {24'h0, w8});
      apb(1'b1, arcbe_pkg::BANK_OFS, {28'h0, bk});
      apb(1'b1, arcbe_pkg::INDEX_OFS, {20'h0, ix});
      apb(1'b1, arcbe_pkg::STATUS_OFS, {27'h0, st});
      apb(1'b1, arcbe_pkg::PC_OFS, {11'h0, pc0});
      ea = exp_addr(a, ext, f, bk, ix);
      res = w8 & fmem(ea, fkey);
      we_cnt = 0;
      run_instr({arcbe_pkg::AND_OPC, d, a, f});
      `CHK("and cycles", 3, lows)
      apb(1'b0, arcbe_pkg::ACCUM_OFS, 32'h0);
      `CHK("accum", {24'h0, d ? w8 : res}, rd)
      est = st;
      est[arcbe_pkg::N_BIT] = res[7];
      est[arcbe_pkg::Z_BIT] = (res == 8'h00);
      apb(1'b0, arcbe_pkg::STATUS_OFS, 32'h0);
      `CHK("and status", {27'h0, est}, rd)
      apb(1'b0, arcbe_pkg::PC_OFS, 32'h0);
      `CHK("and pc", {11'h0, pc0 + arcbe_pkg::PC_STEP}, rd)
      `CHK("write pulses", d ? 1 : 0, we_cnt)
      if (d) begin
        `CHK("file addr", ea, we_addr)
        `CHK("file data", res, we_data)
      end
    end
    for (i = 0; i < 24; i++) begin
      n = (i < 2) ? (i ? 8'h7F : 8'h80) : 8'($random(seed));
      st = $random(seed); pc0 = $random(seed); pc0[0] = 1'b0;
      if (i < 4) st[arcbe_pkg::C_BIT] = ~i[1];
      apb(1'b1, arcbe_pkg::STATUS_OFS, {27'h0, st});
      apb(1'b1, arcbe_pkg::PC_OFS, {11'h0, pc0});
      run_instr({arcbe_pkg::CBR_OPC, n});
      epc = pc0 + arcbe_pkg::PC_STEP;
      if (st[arcbe_pkg::C_BIT])
        epc = epc + {{12{n[7]}}, n, 1'b0};
      `CHK("cbr cycles", st[0] ? 7 : 3, lows)
      `CHK("flush cycles", st[0] ? 4 : 0, fl)
      `CHK("pc port", epc, program_counter)
      apb(1'b0, arcbe_pkg::PC_OFS, 32'h0);
      `CHK("cbr pc", {11'h0, epc}, rd)
      apb(1'b0, arcbe_pkg::STATUS_OFS, 32'h0);
      `CHK("cbr status", {27'h0, st}, rd)
    end
    finish_test();
  end
endmodule
